// ---- prog_seq_pkg.sv ----
// Purpose: constants for the program sequencer and table-read path
// Assumes: word-addressed program memory, one system clock
// Notes: register offsets are byte addresses on the bus
package prog_seq_pkg;
  localparam int PC_WIDTH_MAX = 19;
  localparam int STACK_DEPTH  = 12;
  localparam logic [18:0] VEC_RESET  = 19'h00000;
  localparam logic [18:0] VEC_EXT    = 19'h00004;
  localparam logic [18:0] VEC_TMR0   = 19'h00008;
  localparam logic [18:0] VEC_TMR1   = 19'h0000c;
  localparam logic [18:0] VEC_TMR2   = 19'h00010;
  localparam logic [18:0] VEC_RCOSC  = 19'h00014;
  localparam logic [18:0] VEC_ADPCM  = 19'h00018;
  localparam logic [4:0]  LAST_PAGE  = 5'h1f;
  localparam int NUM_IRQ = 6;
  // register byte offsets
  localparam logic [7:0] REG_TBL_LOW  = 8'h00;
  localparam logic [7:0] REG_TBL_MID  = 8'h04;
  localparam logic [7:0] REG_TBL_HIGH = 8'h08;
  localparam logic [7:0] REG_BANK     = 8'h0c;
  localparam logic [7:0] REG_RESULT_H = 8'h10;
  localparam logic [7:0] REG_IRQ_EN   = 8'h14;
  localparam logic [7:0] REG_STATUS   = 8'h18;
  localparam logic [7:0] REG_PC       = 8'h1c;
  localparam logic [7:0] REG_RESULT_L = 8'h20;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [5:0] RESET_IRQ_EN = 6'h00;
  // instruction cycles a table read takes
  localparam int TABLE_READ_CYCLES = 2;
  typedef enum logic [1:0] {
    SEQ_RUN  = 2'b00,
    SEQ_TBL1 = 2'b01,
    SEQ_TBL2 = 2'b10
  } seq_state_type;
endpackage : prog_seq_pkg

// ---- program_sequencer.sv ----
// Purpose: program counter, return stack, vectoring and table read path
// Assumes: decoder gives one-cycle pulses; rom answers in the same cycle
// Notes: registers reached over AHB-Lite, zero wait states
// Behaviour
// - program counter width follows memory size
// - full stack latches request, withholds acknowledge
// - deferred interrupt served after a pop
// - call on full stack still proceeds
// - program memory is 16-bit words, sized
// - reset loads program counter with zero
// - external low input vectors to 004
// - timer 0 overflow vectors to 008
// - timer 1 overflow vectors to 00c
// - timer 2 or serial vectors to 010
// - rc converter interrupt vectors to 014
// - adpcm interrupt vectors to 018
// - current page address from three pointers
// - last page uses bank, forces ones
// - low byte to data, high byte held
// - unused high bits may be undefined
// - table read takes two instruction cycles
// - result high register is software read-only
// - twelve-level hidden stack reports full
// - call or acknowledge pushes, return pops
`timescale 1ns/1ps
`default_nettype none
module program_sequencer #(
  parameter int PC_WIDTH    = 19,
  parameter bit UART_OPTION = 1'b0
) (
  input  wire  logic                clk,
  input  wire  logic                rst,
  // instruction decoder
  input  wire  logic                cycleEn,
  input  wire  logic                doCall,
  input  wire  logic                doJump,
  input  wire  logic [12:0]         branchTarget,
  input  wire  logic                doReturn,
  input  wire  logic                doReti,
  input  wire  logic                doSkip,
  input  wire  logic                tableReadCurrent,
  input  wire  logic                tableReadLast,
  // interrupt sources
  input  wire  logic                extIntPin_n,
  input  wire  logic                timer0Overflow,
  input  wire  logic                timer1Overflow,
  input  wire  logic                timer2Overflow,
  input  wire  logic                serialIrq,
  input  wire  logic                rc_osc_converter_irq,
  input  wire  logic                adpcmIrq,
  input  wire  logic                globalIntEnable,
  // program rom and sequencer status
  output logic [PC_WIDTH-1:0]       romAddr,
  input  wire  logic [15:0]         romData,
  output logic [PC_WIDTH-1:0]       pc,
  output logic                      intAck,
  output logic [2:0]                intSource,
  output logic                      stackFull,
  output logic                      tableWriteStrobe,
  output logic [7:0]                tableLowByte,
  output logic                      tableBusy,
  // ahb-lite slave
  input  wire  logic                hsel,
  input  wire  logic [31:0]         haddr,
  input  wire  logic [1:0]          htrans,
  input  wire  logic                hwrite,
  input  wire  logic [2:0]          hsize,
  input  wire  logic [31:0]         hwdata,
  input  wire  logic                hready,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp
);
  localparam int SP_W = $clog2(prog_seq_pkg::STACK_DEPTH + 1);

  // pin synchroniser for the external interrupt
  logic extSync1;
  logic extSync2;
  logic extSyncPrev;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      extSync1    <= 1'b1;
      extSync2    <= 1'b1;
      extSyncPrev <= 1'b1;
    end
    else
    begin
      extSync1    <= extIntPin_n;
      extSync2    <= extSync1;
      extSyncPrev <= extSync2;
    end
  end

  // registers and state
  logic [7:0]              table_ptr_low;
  logic [7:0]              table_ptr_mid;
  logic [7:0]              table_ptr_high;
  logic [7:0]              rom_bank_pointer;
  logic [7:0]              table_result_high;
  logic [5:0]              irqEnable;
  logic [5:0]              irqPending;
  logic [SP_W-1:0]         sp;
  logic [PC_WIDTH-1:0]     stackMem [prog_seq_pkg::STACK_DEPTH];
  prog_seq_pkg::seq_state_type state;
  logic                    tblLastSel;
  logic [PC_WIDTH-1:0]     tblAddr;
  logic [7:0]              tableLowReg;

  logic [7:0]              next_table_ptr_low;
  logic [7:0]              next_table_ptr_mid;
  logic [7:0]              next_table_ptr_high;
  logic [7:0]              next_rom_bank_pointer;
  logic [7:0]              next_table_result_high;
  logic [5:0]              next_irqEnable;
  logic [5:0]              next_irqPending;
  logic [SP_W-1:0]         next_sp;
  logic [PC_WIDTH-1:0]     next_pc;
  prog_seq_pkg::seq_state_type next_state;
  logic                    next_tblLastSel;
  logic [PC_WIDTH-1:0]     next_tblAddr;
  logic [7:0]              next_tableLowReg;
  logic                    next_intAck;
  logic [2:0]              next_intSource;
  logic                    next_tableWriteStrobe;
  logic                    pushEn;
  logic [PC_WIDTH-1:0]     pushValue;

  // ahb address phase capture
  logic                    wrPend;
  logic                    rdPend;
  logic [7:0]              busAddr;
  logic                    next_wrPend;
  logic                    next_rdPend;
  logic [7:0]              next_busAddr;
  logic                    addrPhase;

  assign addrPhase = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // raw interrupt events in vector order
  logic [5:0] irqEvent;
  assign irqEvent[0] = extSyncPrev && !extSync2;
  assign irqEvent[1] = timer0Overflow;
  assign irqEvent[2] = timer1Overflow;
  assign irqEvent[3] = timer2Overflow || (UART_OPTION && serialIrq);
  assign irqEvent[4] = rc_osc_converter_irq;
  assign irqEvent[5] = adpcmIrq;

  // vector table lookup
  function automatic logic [18:0] vectorOf(input logic [2:0] idx);
    case (idx)
      3'h0:    vectorOf = prog_seq_pkg::VEC_EXT;
      3'h1:    vectorOf = prog_seq_pkg::VEC_TMR0;
      3'h2:    vectorOf = prog_seq_pkg::VEC_TMR1;
      3'h3:    vectorOf = prog_seq_pkg::VEC_TMR2;
      3'h4:    vectorOf = prog_seq_pkg::VEC_RCOSC;
      default: vectorOf = prog_seq_pkg::VEC_ADPCM;
    endcase
  endfunction : vectorOf

  // fixed priority pick, lowest vector first
  logic [5:0] irqReady;
  logic       irqAny;
  logic [2:0] irqPick;
  assign irqReady = irqPending & irqEnable;
  always_comb
  begin
    irqAny  = 1'b0;
    irqPick = 3'h0;
    for (int i = prog_seq_pkg::NUM_IRQ - 1; i >= 0; i--)
    begin
      if (irqReady[i])
      begin
        irqAny  = 1'b1;
        irqPick = 3'(i);
      end
    end
  end

  // sequencer next state
  always_comb
  begin
    next_pc               = pc;
    next_sp               = sp;
    next_state            = state;
    next_tblLastSel       = tblLastSel;
    next_tblAddr          = tblAddr;
    next_tableLowReg      = tableLowReg;
    next_table_result_high = table_result_high;
    next_intAck           = 1'b0;
    next_intSource        = intSource;
    next_tableWriteStrobe = 1'b0;
    next_irqPending       = irqPending;
    pushEn                = 1'b0;
    pushValue             = pc;
    if (cycleEn)
    begin
      case (state)
        prog_seq_pkg::SEQ_RUN:
        begin
          if (tableReadCurrent || tableReadLast)
          begin
            next_tblLastSel = tableReadLast;
            next_state      = prog_seq_pkg::SEQ_TBL1;
            next_pc         = PC_WIDTH'(pc + 1'b1);
          end
          else if (irqAny && globalIntEnable && !stackFull)
          begin
            pushEn          = 1'b1;
            pushValue       = pc;
            next_sp         = SP_W'(sp + 1'b1);
            next_pc         = PC_WIDTH'(vectorOf(irqPick));
            next_intAck     = 1'b1;
            next_intSource  = irqPick;
            next_irqPending[irqPick] = 1'b0;
          end
          else if (doCall)
          begin
            pushEn    = 1'b1;
            pushValue = PC_WIDTH'(pc + 1'b1);
            if (sp < SP_W'(prog_seq_pkg::STACK_DEPTH))
              next_sp = SP_W'(sp + 1'b1);
            next_pc   = PC_WIDTH'({rom_bank_pointer[5:0], branchTarget});
          end
          else if (doReturn || doReti)
          begin
            if (sp != '0)
            begin
              next_sp = SP_W'(sp - 1'b1);
              next_pc = stackMem[sp - 1'b1];
            end
          end
          else if (doJump)
            next_pc = PC_WIDTH'({rom_bank_pointer[5:0], branchTarget});
          else if (doSkip)
            next_pc = PC_WIDTH'(pc + 2'd2);
          else
            next_pc = PC_WIDTH'(pc + 1'b1);
        end
        prog_seq_pkg::SEQ_TBL1:
        begin
          if (tblLastSel)
            next_tblAddr = PC_WIDTH'({rom_bank_pointer[5:0], prog_seq_pkg::LAST_PAGE,
                                      table_ptr_low});
          else
            next_tblAddr = PC_WIDTH'({table_ptr_high[2:0], table_ptr_mid, table_ptr_low});
          next_state = prog_seq_pkg::SEQ_TBL2;
        end
        prog_seq_pkg::SEQ_TBL2:
        begin
          next_tableLowReg       = romData[7:0];
          next_table_result_high = romData[15:8];
          next_tableWriteStrobe  = 1'b1;
          next_state             = prog_seq_pkg::SEQ_RUN;
        end
        default:
          next_state = prog_seq_pkg::SEQ_RUN;
      endcase
    end
    // new events win over the acknowledge clear
    next_irqPending = next_irqPending | (irqEvent & irqEnable);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pc                <= '0;
      sp                <= '0;
      state             <= prog_seq_pkg::SEQ_RUN;
      tblLastSel        <= 1'b0;
      tblAddr           <= '0;
      tableLowReg       <= prog_seq_pkg::RESET_BYTE;
      table_result_high <= prog_seq_pkg::RESET_BYTE;
      intAck            <= 1'b0;
      intSource         <= 3'h0;
      tableWriteStrobe  <= 1'b0;
      irqPending        <= 6'h00;
    end
    else
    begin
      pc                <= next_pc;
      sp                <= next_sp;
      state             <= next_state;
      tblLastSel        <= next_tblLastSel;
      tblAddr           <= next_tblAddr;
      tableLowReg       <= next_tableLowReg;
      table_result_high <= next_table_result_high;
      intAck            <= next_intAck;
      intSource         <= next_intSource;
      tableWriteStrobe  <= next_tableWriteStrobe;
      irqPending        <= next_irqPending;
    end
  end

  // hidden return stack, overwrites top level on overflow
  always_ff @(posedge clk)
  begin
    if (pushEn)
    begin
      if (sp < SP_W'(prog_seq_pkg::STACK_DEPTH))
        stackMem[sp] <= pushValue;
      else
        stackMem[prog_seq_pkg::STACK_DEPTH-1] <= pushValue;
    end
  end

  assign stackFull    = (sp == SP_W'(prog_seq_pkg::STACK_DEPTH));
  assign romAddr      = (state == prog_seq_pkg::SEQ_TBL2) ? tblAddr : pc;
  assign tableLowByte = tableLowReg;
  assign tableBusy    = (state != prog_seq_pkg::SEQ_RUN);

  // software register writes
  always_comb
  begin
    next_table_ptr_low    = table_ptr_low;
    next_table_ptr_mid    = table_ptr_mid;
    next_table_ptr_high   = table_ptr_high;
    next_rom_bank_pointer = rom_bank_pointer;
    next_irqEnable        = irqEnable;
    next_wrPend           = addrPhase && hwrite;
    next_rdPend           = addrPhase && !hwrite;
    next_busAddr          = addrPhase ? haddr[7:0] : busAddr;
    if (wrPend)
    begin
      case (busAddr)
        prog_seq_pkg::REG_TBL_LOW:  next_table_ptr_low    = hwdata[7:0];
        prog_seq_pkg::REG_TBL_MID:  next_table_ptr_mid    = hwdata[7:0];
        prog_seq_pkg::REG_TBL_HIGH: next_table_ptr_high   = hwdata[7:0];
        prog_seq_pkg::REG_BANK:     next_rom_bank_pointer = hwdata[7:0];
        prog_seq_pkg::REG_IRQ_EN:   next_irqEnable        = hwdata[5:0];
        default:                    next_irqEnable        = irqEnable;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      table_ptr_low    <= prog_seq_pkg::RESET_BYTE;
      table_ptr_mid    <= prog_seq_pkg::RESET_BYTE;
      table_ptr_high   <= prog_seq_pkg::RESET_BYTE;
      rom_bank_pointer <= prog_seq_pkg::RESET_BYTE;
      irqEnable        <= prog_seq_pkg::RESET_IRQ_EN;
      wrPend           <= 1'b0;
      rdPend           <= 1'b0;
      busAddr          <= 8'h00;
    end
    else
    begin
      table_ptr_low    <= next_table_ptr_low;
      table_ptr_mid    <= next_table_ptr_mid;
      table_ptr_high   <= next_table_ptr_high;
      rom_bank_pointer <= next_rom_bank_pointer;
      irqEnable        <= next_irqEnable;
      wrPend           <= next_wrPend;
      rdPend           <= next_rdPend;
      busAddr          <= next_busAddr;
    end
  end

  // read mux, unmapped reads give zero
  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (rdPend)
    begin
      case (busAddr)
        prog_seq_pkg::REG_TBL_LOW:  hrdata = {24'h0, table_ptr_low};
        prog_seq_pkg::REG_TBL_MID:  hrdata = {24'h0, table_ptr_mid};
        prog_seq_pkg::REG_TBL_HIGH: hrdata = {24'h0, table_ptr_high};
        prog_seq_pkg::REG_BANK:     hrdata = {24'h0, rom_bank_pointer};
        prog_seq_pkg::REG_RESULT_H: hrdata = {24'h0, table_result_high};
        prog_seq_pkg::REG_IRQ_EN:   hrdata = {26'h0, irqEnable};
        prog_seq_pkg::REG_STATUS:   hrdata = {20'h0, tableBusy, stackFull, SP_W'(sp), irqPending};
        prog_seq_pkg::REG_PC:       hrdata = 32'(pc);
        prog_seq_pkg::REG_RESULT_L: hrdata = {24'h0, tableLowReg};
        default:                    hrdata = 32'h0000_0000;
      endcase
    end
  end
endmodule : program_sequencer
`default_nettype wire

// ---- rom_model.sv ----
// Purpose: same-cycle program rom standing beside the sequencer
// Assumes: one 16-bit word per word address
// Notes: contents fold the address so every bit moves
`timescale 1ns/1ps
`default_nettype none
module rom_model (
  input  wire logic [18:0] romAddr,
  output logic      [15:0] romData
);
  // word answer in the same cycle, all high bits defined
  assign romData = {romAddr[15:8] ^ {romAddr[18:16], 5'h00}, romAddr[7:0] ^ 8'h3c};
endmodule : rom_model
`default_nettype wire

// ---- prog_seq_monitor.sv ----
// Purpose: port-level checks of the program sequencer
// Assumes: one clock, asynchronous active-high reset
// Notes: bound into every sequencer instance
`timescale 1ns/1ps
`default_nettype none
module prog_seq_monitor #(
  parameter int PC_WIDTH = 19
) (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                cycleEn,
  input wire logic                doCall,
  input wire logic                doReturn,
  input wire logic                doReti,
  input wire logic                tableReadCurrent,
  input wire logic                tableReadLast,
  input wire logic [PC_WIDTH-1:0] romAddr,
  input wire logic [PC_WIDTH-1:0] pc,
  input wire logic                intAck,
  input wire logic [2:0]          intSource,
  input wire logic                stackFull,
  input wire logic                tableWriteStrobe,
  input wire logic                tableBusy,
  input wire logic                hreadyout,
  input wire logic                hresp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic tblGo;
  logic decOk;
  // table start and plain decoder step
  assign tblGo = cycleEn && (tableReadCurrent || tableReadLast) && !tableBusy;
  assign decOk = cycleEn && !tableBusy && !tableReadCurrent && !tableReadLast;
  a_full_no_ack: assert property (intAck |-> !$past(stackFull))
    else $error("acknowledge given on a full stack");
  a_vector_addr: assert property (intAck |-> pc == PC_WIDTH'({intSource + 3'd1, 2'b00}))
    else $error("vector address does not match source");
  a_reset_pc: assert property ($past(rst) && !$past(cycleEn) |-> pc == '0)
    else $error("counter not zero after reset");
  a_table_two: assert property (tblGo ##1 cycleEn [*2] |=> tableWriteStrobe)
    else $error("table read not done in two steps");
  a_strobe_busy: assert property (tableWriteStrobe |-> $past(tableBusy))
    else $error("table strobe without a table read");
  a_call_full: assert property (decOk && doCall && stackFull |=> stackFull)
    else $error("call on full stack changed depth");
  a_ret_frees: assert property (decOk && !doCall && (doReturn || doReti) && stackFull |=> !stackFull)
    else $error("return did not free a level");
  a_full_stays: assert property (stackFull && !cycleEn |=> stackFull)
    else $error("full flag dropped while idle");
  a_rom_pc: assert property (!tableBusy |-> romAddr == pc)
    else $error("rom address differs from counter");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  // main scenarios reached
  c_ack: cover property (intAck);
  c_table: cover property (tableWriteStrobe);
  c_full_call: cover property (decOk && doCall && stackFull);
endmodule : prog_seq_monitor
bind program_sequencer prog_seq_monitor #(.PC_WIDTH(PC_WIDTH)) mon (
  .clk, .rst, .cycleEn, .doCall, .doReturn, .doReti, .tableReadCurrent, .tableReadLast,
  .romAddr, .pc, .intAck, .intSource, .stackFull, .tableWriteStrobe, .tableBusy, .hreadyout, .hresp
);
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: self-checking bench for the program sequencer
// Assumes: rom model answers in the same cycle
// Notes: expectations come from a stack queue and bit models
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0, rst = 1'b1, cycleEn = 1'b0, doCall = 1'b0, doReturn = 1'b0, doReti = 1'b0;
  logic        tableReadCurrent = 1'b0, tableReadLast = 1'b0, hsel = 1'b0, hwrite = 1'b0, gie = 1'b0;
  logic        doJump = 1'b0, doSkip = 1'b0;
  logic [5:0]  irq = 6'h00;
  logic [12:0] branchTarget = 13'h0000;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'b00;
  logic [18:0] romAddr, pc;
  logic [15:0] romData, lf = 16'h8254;
  logic [7:0]  tableLowByte, bk = 8'h00, hiExp = 8'h00;
  logic [2:0]  intSource;
  logic        intAck, stackFull, tableWriteStrobe, tableBusy, hreadyout, hresp;
  int          err_total = 0, n_compared = 0, cyc = 0;
  int          stk[$];
  program_sequencer uut (.clk(clk), .rst(rst), .cycleEn(cycleEn), .doCall(doCall), .doJump(doJump),
    .branchTarget(branchTarget), .doReturn(doReturn), .doReti(doReti), .doSkip(doSkip),
    .tableReadCurrent(tableReadCurrent), .tableReadLast(tableReadLast), .extIntPin_n(~irq[0]),
    .timer0Overflow(irq[1]), .timer1Overflow(irq[2]), .timer2Overflow(irq[3]), .serialIrq(1'b0),
    .rc_osc_converter_irq(irq[4]), .adpcmIrq(irq[5]), .globalIntEnable(gie), .romAddr(romAddr),
    .romData(romData), .pc(pc), .intAck(intAck), .intSource(intSource), .stackFull(stackFull),
    .tableWriteStrobe(tableWriteStrobe), .tableLowByte(tableLowByte), .tableBusy(tableBusy),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  rom_model rom (.romAddr(romAddr), .romData(romData));
  // clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      end_of_test();
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // one single word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  // one decoder step, k = {return_from_interrupt, return, call}
  task automatic step(input logic [2:0] k, input logic [12:0] t);
    @(posedge clk);
    {cycleEn, doReti, doReturn, doCall} <= {1'b1, k};
    branchTarget <= t;
    @(posedge clk);
    {cycleEn, doReti, doReturn, doCall} <= 4'h0;
    @(posedge clk);
    if (k[0] && stk.size() < 12) stk.push_back(1);
    if (k[0]) chk(pc, {bk[5:0], t});
    if (k[2:1] != 2'b00 && stk.size() > 0) void'(stk.pop_back());
    chk(stackFull, stk.size() == 12);
  endtask : step
  task automatic tread(input logic last, input logic [18:0] a);
    int n;
    n = 0;
    @(posedge clk);
    cycleEn <= 1'b1;
    tableReadCurrent <= !last;
    tableReadLast <= last;
    @(posedge clk);
    tableReadCurrent <= 1'b0;
    tableReadLast <= 1'b0;
    while (tableWriteStrobe !== 1'b1 && n < 10)
    begin
      @(posedge clk);
      n++;
    end
    cycleEn <= 1'b0;
    hiExp = a[15:8] ^ {a[18:16], 5'h00};
    chk(n, 3);
    chk(tableLowByte, a[7:0] ^ 8'h3c);
  endtask : tread
  task automatic fire(input logic [5:0] m);
    @(posedge clk);
    irq <= m;
    @(posedge clk);
    irq <= 6'h00;
    repeat (4) @(posedge clk);
  endtask : fire
  task automatic take(input int idx);
    int n;
    n = 0;
    while (intAck !== 1'b1 && n < 30)
    begin
      cycleEn <= 1'b1;
      @(posedge clk);
      n++;
    end
    cycleEn <= 1'b0;
    chk(intSource, idx);
    chk(pc, (idx + 1) * 4);
    stk.push_back(1);
    @(posedge clk);
  endtask : take
  initial
  begin
    logic [31:0] r;
    logic [7:0]  tl, tm, th;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, prog_seq_pkg::REG_PC, 32'h0, r);
    chk(r, 32'h0);
    bus(1'b0, prog_seq_pkg::REG_STATUS, 32'h0, r);
    chk(r, 32'h0);
    bus(1'b0, prog_seq_pkg::REG_IRQ_EN, 32'h0, r);
    chk(r, 32'h0);
    bus(1'b0, 8'h40, 32'h0, r);
    chk(r, 32'h0);
    $display("reset test done");
    for (int k = 0; k < 4; k++)  // interrupts held off here
    begin
      lf = lfsr(lf);
      {tm, tl} = lf;
      lf = lfsr(lf);
      {bk, th} = lf;
      bus(1'b1, prog_seq_pkg::REG_TBL_LOW, {24'h0, tl}, r);
      bus(1'b1, prog_seq_pkg::REG_TBL_MID, {24'h0, tm}, r);
      bus(1'b1, prog_seq_pkg::REG_TBL_HIGH, {24'h0, th}, r);
      bus(1'b1, prog_seq_pkg::REG_BANK, {24'h0, bk}, r);
      tread(1'b0, {th[2:0], tm, tl});
      bus(1'b0, prog_seq_pkg::REG_RESULT_H, 32'h0, r);
      chk(r[7:0], hiExp);
      tread(1'b1, {bk[5:0], 5'h1f, tl});
      bus(1'b1, prog_seq_pkg::REG_RESULT_H, 32'hffff_ffff, r);
      bus(1'b0, prog_seq_pkg::REG_RESULT_H, 32'h0, r);
      chk(r[7:0], hiExp);
    end
    $display("table test done");
    bus(1'b1, prog_seq_pkg::REG_IRQ_EN, 32'h3f, r);
    gie <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      fire(6'h01 << i);
      take(i);
      step(3'b100, 13'h0);
    end
    fire(6'h24);
    take(2);
    take(5);
    step(3'b100, 13'h0);
    step(3'b100, 13'h0);
    // jump to a random target, then skip
    lf = lfsr(lf);
    @(posedge clk);
    {cycleEn, doJump} <= 2'b11;
    branchTarget <= lf[12:0];
    @(posedge clk);
    {doJump, doSkip} <= 2'b01;
    @(posedge clk);
    chk(pc, {bk[5:0], lf[12:0]});
    {cycleEn, doSkip} <= 2'b00;
    @(posedge clk);
    chk(pc, 19'({bk[5:0], lf[12:0]} + 19'd2));
    $display("interrupt test done");
    for (int i = 0; i < 12; i++)
    begin
      lf = lfsr(lf);
      step(3'b001, lf[12:0]);
    end
    fire(6'h02);
    repeat (6)
    begin
      cycleEn <= 1'b1;
      @(posedge clk);
      chk(intAck, 1'b0);
    end
    cycleEn <= 1'b0;
    bus(1'b0, prog_seq_pkg::REG_STATUS, 32'h0, r);
    chk(r[11:0], {1'b0, 1'b1, 4'hc, 6'h02});
    step(3'b001, 13'h1abc);
    step(3'b010, 13'h0);
    take(1);
    $display("stack test done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
